// ### sideband_pkg.sv
package sideband_pkg;

   // Bus clock and derived cycle counts
   localparam int CLK_FREQ_MHZ   = 100;
   localparam int WAKE_PULSE_NS  = 1000;
   localparam int WAKE_PULSE_CYC = (WAKE_PULSE_NS * CLK_FREQ_MHZ + 999) / 1000;
   localparam int WAKE_CNT_W     = 8;

   // Edges a grant needs to clear the pin synchroniser
   localparam int GNT_SETTLE_CYC = 2;

   // Power configuration word, field positions
   localparam int PWR_CFG_W      = 32;
   localparam int WAKE_EN_BIT    = 18;
   localparam int STYLE_SEL_BIT  = 17;

   // Values after reset
   localparam logic RST_OE       = 1'b0;
   localparam logic RST_PIN_N    = 1'b1;
   localparam logic RST_FLAG     = 1'b0;
   localparam logic [WAKE_CNT_W-1:0] RST_CNT = 8'h00;

   // Number of interrupt event sources
   localparam int IRQ_EVENTS     = 8;

   typedef struct packed
   {
      logic out_n;
      logic oe;
   } pin_drive_t;

   typedef enum logic [2:0]
   {
      ARB_IDLE = 3'b001,
      ARB_REQ  = 3'b010,
      ARB_OWN  = 3'b100
   } arb_state_t;

endpackage

// ### pin_sync.sv
`timescale 1ns/1ps

module pin_sync
#(
   parameter int         W       = 1,
   parameter logic [W-1:0] RST_VAL = '0
)
(
   input  wire logic         clk_i,
   input  wire logic         nrst_i,
   input  wire logic [W-1:0] pin_i,
   output logic      [W-1:0] sync_o
);

   logic [W-1:0] meta_r;

   initial
   begin
      if (W < 1)
         $error("pin_sync: W must be at least 1");
   end

   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         meta_r <= RST_VAL;
         sync_o <= RST_VAL;
      end
      else
      begin
         meta_r <= pin_i;
         sync_o <= meta_r;
      end
   end

endmodule

// ### pci_sideband_wake_control.sv
// Behaviour
// - Interrupt line pulled active while enabled event present
// - During reset all pin outputs float, open-drain released
// - Bus signals sampled on bus clock rising edge
// - Request asserted when bus mastership is wanted
// - Master transfer starts only after grant seen
// - Wake event pin is active-low open-drain
// - Wake mode entered when config bit 18 set
// - Wake mode: wake frame asserts event pin
// - Config bit 17 selects lan wake style
// - Open-drain pins only drive low or float
`timescale 1ns/1ps

module pci_sideband_wake_control
#(
   parameter int EVENTS     = sideband_pkg::IRQ_EVENTS,
   parameter int PULSE_CYC  = sideband_pkg::WAKE_PULSE_CYC
)
(
   input  wire logic                               clk_i,
   input  wire logic                               nrst_i,
   input  wire logic [EVENTS-1:0]                  irq_event_i,
   input  wire logic [EVENTS-1:0]                  irq_enable_i,
   output sideband_pkg::pin_drive_t                inta_o,
   input  wire logic                               master_want_i,
   input  wire logic                               master_done_i,
   input  wire logic                               gnt_n_i,
   output sideband_pkg::pin_drive_t                req_o,
   output logic                                    master_start_o,
   output logic                                    master_owned_o,
   input  wire logic [sideband_pkg::PWR_CFG_W-1:0] power_config_register_i,
   input  wire logic                               wake_frame_i,
   input  wire logic                               wake_clear_i,
   input  wire logic                               pme_n_i,
   output sideband_pkg::pin_drive_t                pme_o,
   output logic                                    pme_line_low_o,
   output logic                                    lan_wake_o
);

   import sideband_pkg::*;

   initial
   begin
      if (EVENTS < 1)
         $error("EVENTS must be at least 1");
      if (PULSE_CYC < 1 || PULSE_CYC > 255)
         $error("PULSE_CYC must lie in 1..255");
      if (GNT_SETTLE_CYC < 2 || GNT_SETTLE_CYC > 3)
         $error("GNT_SETTLE_CYC must lie in 2..3");
   end

   function automatic logic cfg_bit(input logic [PWR_CFG_W-1:0] cfg, input int idx);
      cfg_bit = cfg[idx];
   endfunction

   localparam logic [WAKE_CNT_W-1:0] PULSE_LOAD = PULSE_CYC[WAKE_CNT_W-1:0];
   localparam logic [1:0]            GNT_SETTLE = GNT_SETTLE_CYC[1:0];

   // Pin inputs pass two flops before any logic looks at them
   logic [1:0] pins_sync;

   pin_sync #(
      .W       (2),
      .RST_VAL ({RST_PIN_N, RST_PIN_N})
   ) u_pin_sync (
      .clk_i  (clk_i),
      .nrst_i (nrst_i),
      .pin_i  ({pme_n_i, gnt_n_i}),
      .sync_o (pins_sync)
   );

   wire logic gnt_seen = ~pins_sync[0];
   wire logic pme_low  = ~pins_sync[1];

   // Interrupt request
   wire logic irq_any = |(irq_event_i & irq_enable_i);
   pin_drive_t inta_r;
   pin_drive_t inta_nxt;

   always_comb
   begin
      inta_nxt.out_n = 1'b0;
      inta_nxt.oe    = irq_any;
   end

   // Bus request arbitration
   arb_state_t state_r;
   arb_state_t state_nxt;
   logic       start_r;
   logic       start_nxt;
   pin_drive_t req_r;
   pin_drive_t req_nxt;

   // A grant still in the synchroniser may belong to the last request
   logic [1:0] req_age_r;
   wire logic [1:0] req_age_nxt = (state_r != ARB_REQ) ? 2'h0 :
                                  (req_age_r == GNT_SETTLE) ? GNT_SETTLE : req_age_r + 2'h1;
   wire logic gnt_fresh = gnt_seen && (req_age_r == GNT_SETTLE);

   always_comb
   begin
      state_nxt = state_r;
      start_nxt = 1'b0;
      unique case (state_r)
         ARB_IDLE:
         begin
            if (master_want_i)
               state_nxt = ARB_REQ;
         end
         ARB_REQ:
         begin
            if (!master_want_i)
               state_nxt = ARB_IDLE;
            else if (gnt_fresh)
            begin
               state_nxt = ARB_OWN;
               start_nxt = 1'b1;
            end
         end
         ARB_OWN:
         begin
            if (master_done_i)
               state_nxt = ARB_IDLE;
         end
         default:
            state_nxt = ARB_IDLE;
      endcase
   end

   wire logic req_active = (state_nxt != ARB_IDLE) && !(state_nxt == ARB_OWN && master_done_i);

   always_comb
   begin
      req_nxt.out_n = ~req_active;
      req_nxt.oe    = 1'b1;
   end

   // Wake on LAN
   wire logic wake_mode  = cfg_bit(power_config_register_i, WAKE_EN_BIT);
   wire logic style_sel  = cfg_bit(power_config_register_i, STYLE_SEL_BIT);
   wire logic wake_hit   = wake_mode && wake_frame_i;
   logic       wake_pend_r;
   logic [WAKE_CNT_W-1:0] pulse_cnt_r;
   logic       lan_wake_r;
   pin_drive_t pme_r;

   // A wake arriving with the clear keeps the event pending
   wire logic wake_pend_nxt = wake_hit | (wake_pend_r & ~wake_clear_i);

   wire logic [WAKE_CNT_W-1:0] pulse_cnt_nxt =
      wake_hit ? PULSE_LOAD :
      (pulse_cnt_r != RST_CNT) ? pulse_cnt_r - 8'h01 : RST_CNT;

   // Style one is an active-high pulse, the other active-low
   wire logic lan_wake_nxt = (pulse_cnt_nxt != RST_CNT) ? style_sel : ~style_sel;

   wire pin_drive_t pme_nxt = '{out_n: 1'b0, oe: wake_pend_nxt};

   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         state_r     <= ARB_IDLE;
         start_r     <= 1'b0;
         inta_r      <= '{out_n: 1'b0, oe: RST_OE};
         req_r       <= '{out_n: RST_PIN_N, oe: RST_OE};
         pme_r       <= '{out_n: 1'b0, oe: RST_OE};
         wake_pend_r <= RST_FLAG;
         pulse_cnt_r <= RST_CNT;
         lan_wake_r  <= RST_FLAG;
      end
      else
      begin
         state_r     <= state_nxt;
         start_r     <= start_nxt;
         inta_r      <= inta_nxt;
         req_r       <= req_nxt;
         pme_r       <= pme_nxt;
         wake_pend_r <= wake_pend_nxt;
         pulse_cnt_r <= pulse_cnt_nxt;
         lan_wake_r  <= lan_wake_nxt;
      end
   end

   logic own_r;
   logic pme_low_r;

   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         own_r     <= 1'b0;
         pme_low_r <= 1'b0;
         req_age_r <= 2'h0;
      end
      else
      begin
         own_r     <= (state_nxt == ARB_OWN);
         pme_low_r <= pme_low;
         req_age_r <= req_age_nxt;
      end
   end

   assign inta_o         = inta_r;
   assign req_o          = req_r;
   assign pme_o          = pme_r;
   assign master_start_o = start_r;
   assign master_owned_o = own_r;
   assign pme_line_low_o = pme_low_r;
   assign lan_wake_o     = lan_wake_r;

   default clocking cb @(posedge clk_i);
   endclocking

   default disable iff (!nrst_i);

   irq_follows_a: assert property (
      irq_any |=> inta_o.oe
   ) else $error("interrupt line not pulled for an enabled event");

   irq_release_a: assert property (
      !irq_any |=> !inta_o.oe
   ) else $error("interrupt line held with nothing pending");

   od_low_only_a: assert property (
      !inta_o.out_n && !pme_o.out_n
   ) else $error("open-drain pin would drive high");

   start_after_gnt_a: assert property (
      $rose(master_start_o) |-> $past(gnt_seen) && $past(state_r == ARB_REQ)
   ) else $error("master start without grant");

   req_on_want_a: assert property (
      (state_r == ARB_IDLE && master_want_i) |=> !req_o.out_n && req_o.oe
   ) else $error("request not raised when mastership wanted");

   gnt_sampled_a: assert property (
      (state_r == ARB_REQ && master_want_i && !gnt_n_i) [*3] |=> state_r != ARB_REQ
   ) else $error("grant not taken within sampling delay");

   pme_on_wake_a: assert property (
      (wake_frame_i && power_config_register_i[WAKE_EN_BIT]) |=> pme_o.oe && !pme_o.out_n
   ) else $error("wake frame did not assert event pin");

   pme_off_mode_a: assert property (
      (!wake_pend_r && !(wake_frame_i && power_config_register_i[WAKE_EN_BIT])) |=> !pme_o.oe
   ) else $error("event pin asserted outside wake mode");

   pme_set_wins_a: assert property (
      (wake_hit && wake_clear_i) |=> pme_o.oe
   ) else $error("wake lost against clear");

   lan_style_a: assert property (
      wake_hit |=> lan_wake_o == $past(style_sel)
   ) else $error("lan wake pulse has wrong style");

   lan_pulse_end_a: assert property (
      (pulse_cnt_r == 8'h01 && !wake_hit) |=> lan_wake_o != $past(style_sel)
   ) else $error("lan wake pulse length wrong");

   lan_pulse_hold_a: assert property (
      (pulse_cnt_r > 8'h01 && !wake_hit) |=> lan_wake_o == $past(style_sel)
   ) else $error("lan wake pulse ended early");

   lan_idle_a: assert property (
      (nrst_i && pulse_cnt_r == RST_CNT && !wake_hit) |=> lan_wake_o != $past(style_sel)
   ) else $error("lan wake signal not at idle level");

   fresh_gnt_a: assert property (
      $rose(master_start_o) |-> $past(req_age_r) == GNT_SETTLE
   ) else $error("master start on a stale grant");

   start_pulse_a: assert property (
      master_start_o |=> !master_start_o
   ) else $error("master start longer than one cycle");

   start_owned_a: assert property (
      master_start_o |-> master_owned_o
   ) else $error("master start without ownership");

   done_release_a: assert property (
      (state_r == ARB_OWN && master_done_i) |=> req_o.out_n && !master_owned_o
   ) else $error("request held after transfer done");

   want_drop_a: assert property (
      (state_r == ARB_REQ && !master_want_i) |=> req_o.out_n && !master_start_o
   ) else $error("request held after want dropped");

   pme_hold_a: assert property (
      (pme_o.oe && !wake_clear_i) |=> pme_o.oe
   ) else $error("event pin released without clear");

   pme_clear_a: assert property (
      (wake_clear_i && !wake_hit) |=> !pme_o.oe
   ) else $error("event pin held after clear");

   gnt_sync_a: assert property (
      !gnt_n_i |=> ##1 gnt_seen
   ) else $error("grant pin not seen two edges later");

   pme_sync_a: assert property (
      !pme_n_i |=> ##2 pme_line_low_o
   ) else $error("event line low not reported in time");

endmodule

// ### host_model.sv
`timescale 1ns/1ps

module host_model
(
   input  wire logic                     clk_i,
   input  wire logic                     nrst_i,
   input  wire sideband_pkg::pin_drive_t req_i,
   input  wire sideband_pkg::pin_drive_t pme_i,
   input  wire logic [3:0]               gnt_delay_i,
   output logic                          gnt_n_o,
   output logic                          pme_n_o
);
   import sideband_pkg::*;

   logic [3:0] wait_r;

   // Pull-up holds the line high unless a driver sinks it
   assign pme_n_o = !(pme_i.oe && !pme_i.out_n);

   // Grant once the request has stood for the chosen delay
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         wait_r  <= 4'h0;
         gnt_n_o <= 1'b1;
      end
      else if (req_i.oe && !req_i.out_n)
      begin
         wait_r  <= (wait_r == gnt_delay_i) ? wait_r : wait_r + 4'h1;
         gnt_n_o <= (wait_r != gnt_delay_i);
      end
      else
      begin
         wait_r  <= 4'h0;
         gnt_n_o <= 1'b1;
      end
   end
endmodule

// ### tb_pci_sideband_wake_control.sv
`timescale 1ns/1ps

module tb_pci_sideband_wake_control;
   import sideband_pkg::*;

   localparam int PC = 2;

   logic        clk_i  = 1'b0;
   logic        nrst_i = 1'b0;
   logic [7:0]  ev     = 8'h00;
   logic [7:0]  en     = 8'h00;
   logic        want   = 1'b0;
   logic        done   = 1'b0;
   logic        frame  = 1'b0;
   logic        clr    = 1'b0;
   logic [31:0] cfg    = 32'h0;
   logic [31:0] c;
   logic [31:0] r1;
   logic [31:0] r2;
   logic [3:0]  dly    = 4'h0;
   logic        gnt_n;
   logic        pme_n;
   logic        start;
   logic        owned;
   logic        line_low;
   logic        lan;
   logic        exp;
   pin_drive_t  inta;
   pin_drive_t  req;
   pin_drive_t  pme;
   int          seed = 34;
   int          fail_count = 0;
   int          total_checks = 0;
   int          n;

   // Runs above a network bus clock; the logic has no frequency floor
   always #5 clk_i = ~clk_i;

   pci_sideband_wake_control #(.PULSE_CYC(PC)) u_pci_sideband_wake_control
   (
      .clk_i(clk_i), .nrst_i(nrst_i), .irq_event_i(ev), .irq_enable_i(en), .inta_o(inta),
      .master_want_i(want), .master_done_i(done), .gnt_n_i(gnt_n), .req_o(req),
      .master_start_o(start), .master_owned_o(owned), .power_config_register_i(cfg),
      .wake_frame_i(frame), .wake_clear_i(clr), .pme_n_i(pme_n), .pme_o(pme),
      .pme_line_low_o(line_low), .lan_wake_o(lan)
   );

   host_model u_host_model
   (
      .clk_i(clk_i), .nrst_i(nrst_i), .req_i(req), .pme_i(pme),
      .gnt_delay_i(dly), .gnt_n_o(gnt_n), .pme_n_o(pme_n)
   );

   task automatic chk(input logic got, input logic want_v);
   begin
      total_checks++;
      if (got !== want_v)
      begin
         fail_count++;
         $display("BAD %0t: got %b expected %b", $time, got, want_v);
      end
   end
   endtask

   task automatic results;
   begin
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   end
   endtask

   initial
   begin
      repeat (3) @(negedge clk_i);
      chk(inta.oe, 1'b0);
      chk(req.oe, 1'b0);
      chk(pme.oe, 1'b0);
      repeat (3) @(posedge clk_i);
      // Far shorter than a host holds it; the logic settles in one edge
      nrst_i <= 1'b1;
      @(posedge clk_i);
      @(negedge clk_i);
      chk(req.oe, 1'b1);
      chk(req.out_n, 1'b1);
      chk(lan, 1'b1);
      $display("reset test done");
      repeat (40)
      begin
         @(posedge clk_i);
         r1 = $random(seed);
         r2 = $random(seed);
         ev <= r1[7:0];
         en <= r2[7:0] & r1[15:8];
         exp = |(r1[7:0] & r2[7:0] & r1[15:8]);
         @(posedge clk_i);
         @(negedge clk_i);
         chk(inta.oe, exp);
         chk(inta.out_n, 1'b0);
      end
      $display("interrupt test done");
      for (int d = 0; d < 8; d += 7)
      begin
         @(posedge clk_i);
         dly  <= d[3:0];
         want <= 1'b1;
         n = 0;
         @(negedge clk_i);
         while (start !== 1'b1 && n < 40)
         begin
            @(negedge clk_i);
            n++;
         end
         if (n == 40)
         begin
            fail_count++;
            results;
         end
         chk(n == 5 + d, 1'b1);
         chk(gnt_n, 1'b0);
         chk(req.out_n, 1'b0);
         chk(owned, 1'b1);
         @(negedge clk_i);
         chk(start, 1'b0);
         @(posedge clk_i);
         done <= 1'b1;
         want <= 1'b0;
         @(posedge clk_i);
         done <= 1'b0;
         @(negedge clk_i);
         chk(req.out_n, 1'b1);
         chk(owned, 1'b0);
      end
      // Request raised while the last grant is still in the synchroniser, then dropped before the grant
      @(posedge clk_i);
      want <= 1'b1;
      repeat (3) @(posedge clk_i);
      want <= 1'b0;
      @(negedge clk_i);
      chk(req.out_n, 1'b0);
      @(negedge clk_i);
      chk(req.out_n, 1'b1);
      chk(owned, 1'b0);
      chk(gnt_n, 1'b1);
      $display("arbitration test done");
      for (int i = 0; i < 4; i++)
      begin
         @(posedge clk_i);
         c = 32'h0;
         c[WAKE_EN_BIT] = i[1];
         c[STYLE_SEL_BIT] = i[0];
         cfg <= c;
         @(posedge clk_i);
         frame <= 1'b1;
         @(posedge clk_i);
         frame <= 1'b0;
         @(negedge clk_i);
         chk(pme.oe, i[1]);
         chk(pme_n, !i[1]);
         chk(lan, i[1] ? i[0] : !i[0]);
         repeat (PC) @(negedge clk_i);
         chk(lan, !i[0]);
         repeat (2) @(negedge clk_i);
         chk(line_low, i[1]);
         @(posedge clk_i);
         clr <= 1'b1;
         @(posedge clk_i);
         clr <= 1'b0;
         @(negedge clk_i);
         chk(pme.oe, 1'b0);
         chk(pme.out_n, 1'b0);
      end
      // Wake frame and clear in one cycle: the wake wins
      @(posedge clk_i);
      frame <= 1'b1;
      clr   <= 1'b1;
      @(posedge clk_i);
      frame <= 1'b0;
      clr   <= 1'b0;
      @(negedge clk_i);
      chk(pme.oe, 1'b1);
      chk(lan, 1'b1);
      @(posedge clk_i);
      clr <= 1'b1;
      @(posedge clk_i);
      clr <= 1'b0;
      @(negedge clk_i);
      chk(pme.oe, 1'b0);
      $display("wake test done");
      results;
   end
endmodule
